// ==== inc/dpw_cfg.svh ====
/*
 * timing constants for the dual-port sram write host.
 * assumes a 20 MHz clock; times in ns, counts derived from them.
 */
`ifndef DPW_CFG_SVH
`define DPW_CFG_SVH
`define DPW_CLK_NS 50
// least times round up to whole cycles, never below one
`define DPW_CYC(t) ((((t) + `DPW_CLK_NS - 1) / `DPW_CLK_NS) < 1 ? 1 : (((t) + `DPW_CLK_NS - 1) / `DPW_CLK_NS))
`define DPW_T_EW_NS 12
`define DPW_T_WP_NS 12
`define DPW_T_WZ_NS 10
`define DPW_T_DW_NS 10
`define DPW_T_DH_NS 0
`define DPW_T_SWRD_NS 5
`define DPW_T_AS_NS 0
`define DPW_RD_CYC 2
`define DPW_ADDR_W 15
`define DPW_DATA_W 8
`define DPW_CNT_W 4
`endif

// ==== inc/dpw_pkg.sv ====
/*
 * types for the dual-port sram write host.
 * assumes dpw_cfg.svh is included before use of the timing macros.
 */
package dpw_pkg;
    typedef enum logic [2:0] {
        DPW_IDLE,
        DPW_SETUP,
        DPW_STROBE,
        DPW_HOLD,
        DPW_GAP,
        DPW_READ
    } dpw_state_e;
endpackage

// ==== rtl/dpw_host.sv ====
/*
 * host controller that writes the array or a semaphore flag of one port of
 * an asynchronous dual-port sram, and can read a flag back afterwards.
 * assumes the memory pins are wired to this module, and one port per instance.
 */
`timescale 1ns/10ps
`include "dpw_cfg.svh"

module dpw_host
    import dpw_pkg::*;
#(
    parameter int ADDR_W = `DPW_ADDR_W,
    parameter int DATA_W = `DPW_DATA_W
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic req_i,
    input wire logic req_flag_i,
    input wire logic req_read_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_data_i,
    output logic ready_o,
    output logic done_o,
    output logic [DATA_W-1:0] rd_data_o,
    output logic chip_en_n_o,
    output logic flag_select_n_o,
    output logic write_n_o,
    output logic out_en_n_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    input wire logic [DATA_W-1:0] data_i
);
    // ************************************************************
    // timing counts
    // ************************************************************
    // the larger of two least times, used for both strobe terms
    function automatic int max_of(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    // output enable stays high, so the turnoff term is only a margin here
    localparam int STB_NS = max_of(`DPW_T_WZ_NS + `DPW_T_DW_NS, `DPW_T_WP_NS);
    localparam int STB_RAW = `DPW_CYC(STB_NS);
    localparam int EW_RAW = `DPW_CYC(`DPW_T_EW_NS);
    // enable and strobe share one counter, so the longer need sets both
    localparam int STB_C = max_of(STB_RAW, EW_RAW);
    localparam int GAP_C = `DPW_CYC(`DPW_T_SWRD_NS);
    localparam int RD_C = `DPW_RD_CYC;
    localparam logic [`DPW_CNT_W-1:0] STB_LAST = `DPW_CNT_W'(STB_C - 1);
    localparam logic [`DPW_CNT_W-1:0] GAP_LAST = `DPW_CNT_W'(GAP_C - 1);
    localparam logic [`DPW_CNT_W-1:0] RD_LAST = `DPW_CNT_W'(RD_C - 1);
    localparam logic [`DPW_CNT_W-1:0] CNT_ONE = `DPW_CNT_W'(1);

    // ************************************************************
    // state
    // ************************************************************
    dpw_state_e state, next_state;
    logic [`DPW_CNT_W-1:0] cnt, next_cnt;
    logic flag, next_flag;
    logic rd, next_rd;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_data, next_rd_data;
    logic next_done;

    // a request while busy is dropped, not queued; the caller waits for ready
    assign ready_o = (state == DPW_IDLE);

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_flag = flag;
        next_rd = rd;
        next_addr = addr_o;
        next_data = data_o;
        next_rd_data = rd_data_o;
        next_done = 1'b0;
        unique case (state)
            DPW_IDLE: begin
                if (req_i) begin
                    // address and data settle while strobe is high
                    next_addr = req_addr_i;
                    next_data = req_data_i;
                    next_flag = req_flag_i;
                    // read-back exists for flags only; array reads are not offered
                    next_rd = req_flag_i && req_read_i;
                    next_state = DPW_SETUP;
                end
            end
            DPW_SETUP: begin
                // one quiet cycle lets the address settle before the strobe falls
                next_cnt = '0;
                next_state = DPW_STROBE;
            end
            DPW_STROBE: begin
                // one counter times both enable width and strobe width
                next_cnt = cnt + CNT_ONE;
                if (cnt == STB_LAST) begin
                    next_state = DPW_HOLD;
                end
            end
            DPW_HOLD: begin
                // data stays one cycle after release, covering zero hold
                next_cnt = '0;
                if (rd) begin
                    next_state = DPW_GAP;
                end else begin
                    next_done = 1'b1;
                    next_state = DPW_IDLE;
                end
            end
            DPW_GAP: begin
                // all pins idle here, which is the flag write-to-read spacing
                next_cnt = cnt + CNT_ONE;
                if (cnt == GAP_LAST) begin
                    next_cnt = '0;
                    next_state = DPW_READ;
                end
            end
            DPW_READ: begin
                // value taken in the last read cycle, after a full cycle of drive
                next_cnt = cnt + CNT_ONE;
                if (cnt == RD_LAST) begin
                    next_rd_data = data_i;
                    next_done = 1'b1;
                    next_state = DPW_IDLE;
                end
            end
        endcase
    end

    // ************************************************************
    // sequencer registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= DPW_IDLE;
            cnt <= '0;
            flag <= 1'b0;
            rd <= 1'b0;
            addr_o <= '0;
            data_o <= '0;
            rd_data_o <= '0;
            done_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            flag <= next_flag;
            rd <= next_rd;
            addr_o <= next_addr;
            data_o <= next_data;
            rd_data_o <= next_rd_data;
            done_o <= next_done;
        end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    // pin values follow the next state so they switch on the state's edge
    logic next_ce_n, next_fs_n, next_we_n, next_oe_n, next_doe_n;
    always_comb begin
        // on a write, enable and strobe fall together and rise together; a flag read drops flag select with no strobe
        next_ce_n = 1'b1;
        next_fs_n = 1'b1;
        next_we_n = 1'b1;
        next_oe_n = 1'b1;
        next_doe_n = 1'b1;
        unique case (next_state)
            DPW_STROBE: begin
                next_ce_n = next_flag;
                next_fs_n = ~next_flag;
                next_we_n = 1'b0;
                // host drives only while the device outputs are already off
                next_doe_n = 1'b0;
            end
            DPW_HOLD: begin
                next_doe_n = 1'b0;
            end
            DPW_READ: begin
                // chip enable stays high across the flag write and its read
                next_fs_n = 1'b0;
                next_oe_n = 1'b0;
            end
            default: begin
            end
        endcase
    end

    // registered pins, so no combinational glitch reaches the device strobes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            // every enable released, so reset can never cause a stray write
            chip_en_n_o <= 1'b1;
            flag_select_n_o <= 1'b1;
            write_n_o <= 1'b1;
            out_en_n_o <= 1'b1;
            data_oe_n_o <= 1'b1;
        end else begin
            chip_en_n_o <= next_ce_n;
            flag_select_n_o <= next_fs_n;
            write_n_o <= next_we_n;
            out_en_n_o <= next_oe_n;
            data_oe_n_o <= next_doe_n;
        end
    end
endmodule // dpw_host

// ==== tb/dpw_host_monitor.sv ====
/* pin checker for dpw_host. assumes a bind from the bench top file. */
`timescale 1ns/10ps
module dpw_host_monitor #(parameter int ADDR_W = 15, parameter int DATA_W = 8) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic done_o,
    input wire logic chip_en_n_o,
    input wire logic flag_select_n_o,
    input wire logic write_n_o,
    input wire logic out_en_n_o,
    input wire logic data_oe_n_o,
    input wire logic [ADDR_W-1:0] addr_o,
    input wire logic [DATA_W-1:0] data_o
);
    // ****************
    // pin rules
    // ****************
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sel_one_a: assert property (!write_n_o |-> chip_en_n_o != flag_select_n_o) else $error("bad select");
    addr_still_a: assert property (!write_n_o |-> $stable(addr_o)) else $error("addr moved");
    bus_free_a: assert property (!data_oe_n_o |-> out_en_n_o) else $error("bus fight");
    en_with_a: assert property ($fell(write_n_o) |-> $fell(chip_en_n_o) || $fell(flag_select_n_o)) else $error("enable");
    drive_with_a: assert property ($fell(write_n_o) |-> !data_oe_n_o) else $error("no data");
    hold_end_a: assert property ($fell(write_n_o) |=> write_n_o && !data_oe_n_o ##1 data_oe_n_o) else $error("hold");
    data_keep_a: assert property (!data_oe_n_o |-> $stable(data_o)) else $error("data moved");
    read_gap_a: assert property ($fell(out_en_n_o) |-> $past(write_n_o, 2) && chip_en_n_o) else $error("gap");
    cover property ($fell(chip_en_n_o));
    cover property ($fell(out_en_n_o));
    cover property (!out_en_n_o ##1 done_o);
endmodule // dpw_host_monitor

// ==== tb/dpw_sram_model.sv ====
/* one port of the dual-port ram with flags. assumes peer_own_i tells a far-port hold. */
`timescale 1ns/10ps
module dpw_sram_model #(parameter int ADDR_W = 15, parameter int DATA_W = 8) (
    input wire logic chip_en_n_i,
    input wire logic flag_select_n_i,
    input wire logic write_n_i,
    input wire logic out_en_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic peer_own_i,
    output logic [DATA_W-1:0] data_o
);
    // ****************
    // array and flags
    // ****************
    logic [DATA_W-1:0] mem [0:15];
    logic [7:0] own = 8'h00;
    // latch at the first release of the overlap; same for either port
    always @(posedge (chip_en_n_i | write_n_i)) if (flag_select_n_i) mem[addr_i[3:0]] = data_i;
    always @(posedge (flag_select_n_i | write_n_i)) begin
        if (chip_en_n_i) own[addr_i[2:0]] = !data_i[0] && !peer_own_i;
    end
    // a flag read shows the inverse; the released bus shows the flag itself, never a stale value
    always_comb begin
        if (!out_en_n_i && !flag_select_n_i && chip_en_n_i && write_n_i) data_o = {DATA_W{~own[addr_i[2:0]]}};
        else data_o = {DATA_W{own[addr_i[2:0]]}};
    end
endmodule // dpw_sram_model

// ==== tb/dual_port_sram_write_semaphore_test.sv ====
/* bench for dpw_host. assumes the device model drives data_i. */
`timescale 1ns/10ps
module dual_port_sram_write_semaphore_test;
    logic clk_i = 0, srst_i = 1, req_i = 0, req_flag_i = 0, req_read_i = 0, peer_own = 0;
    logic [14:0] req_addr_i = '0, addr_o;
    logic [7:0] req_data_i = '0, rd_data_o, data_i, data_o;
    logic ready_o, done_o, chip_en_n_o, flag_select_n_o, write_n_o, out_en_n_o, data_oe_n_o;
    int miscompares = 0, num_checks = 0, cyc = 0, n;
    dpw_host uut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i), .req_flag_i(req_flag_i), .req_read_i(req_read_i),
        .req_addr_i(req_addr_i), .req_data_i(req_data_i), .ready_o(ready_o), .done_o(done_o), .rd_data_o(rd_data_o),
        .chip_en_n_o(chip_en_n_o), .flag_select_n_o(flag_select_n_o), .write_n_o(write_n_o), .out_en_n_o(out_en_n_o),
        .addr_o(addr_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o), .data_i(data_i));
    dpw_sram_model dev (.chip_en_n_i(chip_en_n_o), .flag_select_n_i(flag_select_n_o), .write_n_i(write_n_o),
        .out_en_n_i(out_en_n_o), .addr_i(addr_o), .data_i(data_o), .peer_own_i(peer_own), .data_o(data_i));
    initial forever #25 clk_i = ~clk_i;
    // ****************
    // helpers
    // ****************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic op(input logic f, input logic r, input logic [14:0] a, input logic [7:0] d);
        {req_i, req_flag_i, req_read_i, req_addr_i, req_data_i} = {1'b1, f, r, a, d};
        n = 0;
        @(posedge clk_i);
        #1 req_i = 0;
        while (done_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1 n++;
        end
        if (n >= 20) begin
            miscompares++;
            tally_and_finish;
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        {req_i, req_flag_i, req_read_i, req_addr_i, req_data_i} = {1'b1, 1'b1, 1'b1, 15'h2, 8'h00};
        @(posedge clk_i);
        #1 req_i = 0;
        srst_i = 1;
        @(posedge clk_i);
        #1 srst_i = 0;
        check({ready_o, done_o, chip_en_n_o, flag_select_n_o, write_n_o, out_en_n_o, data_oe_n_o, 1'b0}, 8'hbe);
        check(addr_o[7:0], 8'h00);
        check({7'h0, dev.own[2]}, 8'h00);
    endtask
    task automatic t_array;
        op(0, 0, 15'h5, 8'ha5);
        check(8'(n), 8'h3);
        op(0, 0, 15'h6, 8'h3c);
        check(dev.mem[5], 8'ha5);
        check(dev.mem[6], 8'h3c);
    endtask
    task automatic t_flag_take;
        op(1, 1, 15'h3, 8'h00);
        check(8'(n), 8'h6);
        check(rd_data_o, 8'h00);
    endtask
    task automatic t_flag_busy;
        peer_own = 1;
        op(1, 1, 15'h4, 8'h00);
        check(rd_data_o, 8'hff);
        peer_own = 0;
    endtask
    task automatic t_flag_free;
        op(1, 1, 15'h3, 8'h01);
        check(rd_data_o, 8'hff);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 500) begin
            miscompares++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        #1 srst_i = 0;
        t_reset;
        t_array;
        t_flag_take;
        t_flag_busy;
        t_flag_free;
        tally_and_finish;
    end
endmodule // dual_port_sram_write_semaphore_test
bind dpw_host dpw_host_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon (.clk_i(clk_i), .srst_i(srst_i),
    .done_o(done_o), .chip_en_n_o(chip_en_n_o), .flag_select_n_o(flag_select_n_o), .write_n_o(write_n_o),
    .out_en_n_o(out_en_n_o), .data_oe_n_o(data_oe_n_o), .addr_o(addr_o), .data_o(data_o));
